// ---- design/ivsc_pkg.sv ----
// package for the interrupt vector and special function register controller
package ivsc_pkg;

  // sfr byte offsets in the lowest address space
  localparam logic [3:0] IE_FIRST_OFFSET  = 4'h0;
  localparam logic [3:0] IE_SECOND_OFFSET = 4'h1;
  localparam logic [3:0] IFG_FIRST_OFFSET = 4'h2;
  localparam logic [3:0] IFG_SECOND_OFFSET = 4'h3;
  localparam logic [3:0] ME_FIRST_OFFSET  = 4'h4;
  localparam logic [3:0] ME_SECOND_OFFSET = 4'h5;

  // bit positions in the first enable byte and first flag byte
  localparam int WDOG_BIT  = 0;
  localparam int OSC_BIT   = 1;
  localparam int NMI_BIT   = 4;
  localparam int FLASH_BIT = 5;
  // bit position in the second enable and flag bytes
  localparam int TICK_BIT  = 7;

  // implemented bit masks; other positions have no storage
  localparam logic [7:0] IE_FIRST_MASK   = 8'h33;
  localparam logic [7:0] IE_SECOND_MASK  = 8'h80;
  localparam logic [7:0] IFG_FIRST_MASK  = 8'h13;
  localparam logic [7:0] IFG_SECOND_MASK = 8'h80;

  // reset values
  localparam logic [7:0] IE_RESET  = 8'h00;
  localparam logic [7:0] IFG_RESET = 8'h00;
  localparam logic [7:0] ME_RESET  = 8'h00;

  // vector table: lowest word and the priority levels used
  localparam logic [15:0] VECTOR_BASE   = 16'hffe0;
  localparam logic [3:0]  PRIO_RESET    = 4'hf;
  localparam logic [3:0]  PRIO_NMI      = 4'he;
  localparam logic [3:0]  PRIO_WDOG     = 4'ha;
  localparam logic [3:0]  PRIO_TIMER_GRP = 4'h5;
  localparam logic [3:0]  PRIO_PORT_ONE = 4'h4;
  localparam logic [3:0]  PRIO_PORT_TWO = 4'h1;
  localparam logic [3:0]  PRIO_TICK     = 4'h0;

  // sfr byte access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ivsc_sfr_req_t;

  // all state of the controller
  typedef struct packed {
    logic [7:0]  ie_first;
    logic [7:0]  ie_second;
    logic [7:0]  ifg_first;
    logic [7:0]  ifg_second;
    logic [7:0]  me_first;
    logic [7:0]  me_second;
    logic [7:0]  rdata;
    logic        irq_req;
    logic [15:0] vec_addr;
    logic [3:0]  vec_level;
    logic [1:0]  pin_sync;
    logic        pin_last;
    logic        por_done;
  } ivsc_state_t;

endpackage

// ---- design/ivsc_top.sv ----
// interrupt vectoring, priority resolution and special function register bytes
`timescale 1ns/10ps
// Notes on behaviour
// [R01] vectors occupy top words down to lowest vector
// [R02] vector word holds full 16-bit handler address
// [R03] pin nmi, osc fault, flash share level 14
// [R04] global enable never blocks the shared nmi vector
// [R05] each nmi-group source has own enable bit
// [R06] timer channels and overflow share level 5
// [R07] first port's eight pin flags share level 4
// [R08] second port's eight pin flags share level 1
// [R09] shared vector requests while any member pending
// [R10] maskable peripheral flags live in their modules
// [R11] enable bits collected in low sfr bytes
// [R12] unassigned sfr bits have no storage
// [R13] watchdog enable gates only in interval mode
// [R14] watchdog flag on reset-mode overflow or bad key
// [R15] watchdog flag cleared by power-up or pin reset
// [R16] osc fault flag set on detected fault
// [R17] pin nmi flag set by nmi-mode pin event
// [R18] two module-enable bytes at consecutive addresses
// [R19] sfr bits read-write, cleared by their reset; watchdog flag ignores writes
// [R20] highest pending level wins; nmi ignores global enable
// [R21] software finds and clears shared-vector sources
module ivsc_top
  import ivsc_pkg::*;
#(
  parameter int LEVELS = 16
) (
  // clock, reset, enable
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 power_on_clear,
  // sfr byte port from the core
  input  wire ivsc_pkg::ivsc_sfr_req_t sfr_req,
  output logic [7:0]                sfr_rdata,
  // core status
  input  wire logic                 global_irq_enable,
  // reset/nmi pin and its mode
  input  wire logic                 reset_nmi_pin,
  input  wire logic                 pin_nmi_mode,
  input  wire logic                 pin_reset_event,
  // system event sources
  input  wire logic                 osc_fault_detect,
  input  wire logic                 flash_violation_event,
  input  wire logic                 flash_key_violation,
  input  wire logic                 watchdog_overflow,
  input  wire logic                 watchdog_interval_mode,
  input  wire logic                 tick_timer_event,
  // module-owned request lines
  input  wire logic [LEVELS-1:0]    periph_req,
  input  wire logic [2:0]           compare_channel_flag,
  input  wire logic [7:0]           port_one_pin_flags,
  input  wire logic [7:0]           port_two_pin_flags,
  // vector answer to the core
  output logic                      irq_pending,
  output logic [15:0]               irq_vector_addr,
  output logic [3:0]                irq_level
);

  ivsc_state_t st_reg;
  ivsc_state_t st_next;
  logic [LEVELS-1:0] req;
  logic              pin_edge;
  logic [7:0]        wmask;

  // request vector; peripheral flags stay in their modules
  always_comb begin
    req = periph_req;                                                 // [R10]
    req[PRIO_TIMER_GRP] = |compare_channel_flag;                      // [R06] [R09]
    req[PRIO_PORT_ONE]  = |port_one_pin_flags;                        // [R07] [R09]
    req[PRIO_PORT_TWO]  = |port_two_pin_flags;                        // [R08] [R09]
    req[PRIO_TICK]      = st_reg.ifg_second[TICK_BIT] & st_reg.ie_second[TICK_BIT];
    req[PRIO_WDOG]      = st_reg.ifg_first[WDOG_BIT] & st_reg.ie_first[WDOG_BIT]
                          & watchdog_interval_mode;                   // [R13]
    req[PRIO_RESET]     = 1'b0;
    // each nmi-group member gated by its own enable only
    req[PRIO_NMI] = (st_reg.ifg_first[NMI_BIT] & st_reg.ie_first[NMI_BIT])
                  | (st_reg.ifg_first[OSC_BIT] & st_reg.ie_first[OSC_BIT])
                  | (flash_violation_event & st_reg.ie_first[FLASH_BIT]); // [R03] [R05]
  end

  // pin edge seen only after the two-stage synchroniser
  assign pin_edge = st_reg.pin_sync[1] & ~st_reg.pin_last;

  // next state
  always_comb begin
    st_next = st_reg;
    wmask   = 8'h00;
    st_next.pin_sync = {st_reg.pin_sync[0], reset_nmi_pin};
    st_next.pin_last = st_reg.pin_sync[1];
    st_next.por_done = 1'b1;

    // byte writes keep only implemented bits
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        IE_FIRST_OFFSET:   st_next.ie_first   = sfr_req.wdata & IE_FIRST_MASK;   // [R11] [R12]
        IE_SECOND_OFFSET:  st_next.ie_second  = sfr_req.wdata & IE_SECOND_MASK;
        IFG_FIRST_OFFSET:  wmask = IFG_FIRST_MASK;
        IFG_SECOND_OFFSET: st_next.ifg_second = sfr_req.wdata & IFG_SECOND_MASK;
        ME_FIRST_OFFSET:   st_next.me_first   = sfr_req.wdata;                   // [R18]
        ME_SECOND_OFFSET:  st_next.me_second  = sfr_req.wdata;                   // [R18]
        default: ;
      endcase
    end
    // watchdog flag not writable; only its resets clear it
    if (wmask != 8'h00) begin
      st_next.ifg_first = (sfr_req.wdata & wmask & ~8'h01)
                        | (st_reg.ifg_first & 8'h01);                            // [R15] [R19]
    end

    // pin reset in reset mode clears the watchdog flag
    if (pin_reset_event & ~pin_nmi_mode)
      st_next.ifg_first[WDOG_BIT] = 1'b0;                                        // [R15]

    // hardware sets come last so they win over any sfr-write or pin-reset clear in the same cycle
    if (watchdog_overflow | flash_key_violation)
      st_next.ifg_first[WDOG_BIT] = 1'b1;                                        // [R14]
    if (osc_fault_detect)
      st_next.ifg_first[OSC_BIT] = 1'b1;                                         // [R16]
    if (pin_edge & pin_nmi_mode)
      st_next.ifg_first[NMI_BIT] = 1'b1;                                         // [R17]
    if (tick_timer_event)
      st_next.ifg_second[TICK_BIT] = 1'b1;

    // registered read data, zeros for absent bits
    unique case (sfr_req.addr)
      IE_FIRST_OFFSET:   st_next.rdata = st_reg.ie_first;
      IE_SECOND_OFFSET:  st_next.rdata = st_reg.ie_second;
      IFG_FIRST_OFFSET:  st_next.rdata = st_reg.ifg_first;
      IFG_SECOND_OFFSET: st_next.rdata = st_reg.ifg_second;
      ME_FIRST_OFFSET:   st_next.rdata = st_reg.me_first;
      ME_SECOND_OFFSET:  st_next.rdata = st_reg.me_second;
      default:           st_next.rdata = 8'h00;
    endcase
    if (!sfr_req.rd)
      st_next.rdata = 8'h00;

    // priority resolution, highest level first
    st_next.irq_req   = 1'b0;
    st_next.vec_level = PRIO_TICK;
    if (!st_reg.por_done) begin
      st_next.irq_req   = 1'b1;                                                  // [R20]
      st_next.vec_level = PRIO_RESET;
    end else if (req[PRIO_NMI]) begin
      st_next.irq_req   = 1'b1;                                                  // [R04] [R20]
      st_next.vec_level = PRIO_NMI;
    end else if (global_irq_enable) begin
      for (int i = 0; i < LEVELS - 2; i++) begin
        if (req[i]) begin
          st_next.irq_req   = 1'b1;                                              // [R20]
          st_next.vec_level = 4'(i);
        end
      end
    end
    // word address = base + 2 * level
    st_next.vec_addr = VECTOR_BASE + {11'h000, st_next.vec_level, 1'b0};        // [R01] [R02]
  end

  // state register; power-on clear resets every sfr byte but the first flag byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.vec_addr  <= VECTOR_BASE;
      st_reg.ie_first  <= IE_RESET;
      st_reg.ifg_first <= IFG_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
      if (power_on_clear) begin
        st_reg.ie_first   <= IE_RESET;                                           // [R19]
        st_reg.ie_second  <= IE_RESET;
        st_reg.me_first   <= ME_RESET;
        st_reg.me_second  <= ME_RESET;
        st_reg.ifg_second <= IFG_RESET;
      end
    end
  end

  // outputs straight from flip-flops
  assign sfr_rdata       = st_reg.rdata;
  assign irq_pending     = st_reg.irq_req;
  assign irq_vector_addr = st_reg.vec_addr;
  assign irq_level       = st_reg.vec_level;

endmodule // ivsc_top

// ---- verif/ivsc_sva.sv ----
// assertions on the vector and sfr ports of the controller
`timescale 1ns/10ps
module ivsc_sva import ivsc_pkg::*; #(parameter int LEVELS = 16) (
  // clock and control
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    clk_en,
  input wire logic                    global_irq_enable,
  // sfr port
  input wire ivsc_pkg::ivsc_sfr_req_t sfr_req,
  input wire logic [7:0]              sfr_rdata,
  // grouped request lines
  input wire logic [2:0]              compare_channel_flag,
  input wire logic [7:0]              port_one_pin_flags,
  input wire logic [7:0]              port_two_pin_flags,
  // vector answer
  input wire logic irq_pending,
  input wire logic [15:0] irq_vector_addr,
  input wire logic [3:0] irq_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a request at or above a level is shown
  sequence at_least(int lv);
    irq_pending && irq_level >= lv;
  endsequence
  sequence open_en;
    clk_en && global_irq_enable;
  endsequence
  chk_vec_word: assert property (irq_pending |-> irq_vector_addr == (VECTOR_BASE | {irq_level, 1'b0}))
    else $error("vector word wrong");
  chk_timer_grp: assert property (open_en and |compare_channel_flag |=> at_least(5))
    else $error("timer group lost");
  chk_port_one: assert property (open_en and |port_one_pin_flags |=> at_least(4))
    else $error("port one group lost");
  chk_port_two: assert property (open_en and |port_two_pin_flags |=> at_least(1))
    else $error("port two group lost");
  // a frozen cycle keeps an older decision, so only judge freshly resolved vectors
  chk_gie_mask: assert property ($past(clk_en) && irq_pending && irq_level < PRIO_NMI |-> $past(global_irq_enable))
    else $error("maskable request while disabled");
  chk_rd_idle: assert property (clk_en && (!sfr_req.rd || sfr_req.addr > ME_SECOND_OFFSET) |=> sfr_rdata == 8'h00)
    else $error("read data not zero");
  chk_ie_bits: assert property (clk_en && sfr_req.rd && sfr_req.addr == IE_FIRST_OFFSET |=> (sfr_rdata & ~IE_FIRST_MASK) == 8'h00)
    else $error("absent enable bit reads one");
  // reset vector shown once, for one cycle only
  chk_reset_vec: assert property ($rose(rst_n) && clk_en |=> (irq_pending && irq_level == PRIO_RESET) ##1 irq_level != PRIO_RESET)
    else $error("reset vector wrong");
endmodule // ivsc_sva
bind ivsc_top ivsc_sva #(.LEVELS(LEVELS)) sva_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .global_irq_enable(global_irq_enable), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .compare_channel_flag(compare_channel_flag), .port_one_pin_flags(port_one_pin_flags),
  .port_two_pin_flags(port_two_pin_flags), .irq_pending(irq_pending),
  .irq_vector_addr(irq_vector_addr), .irq_level(irq_level));

// ---- verif/ivsc_core_model.sv ----
// core model: holds the global enable and fetches the vector word
`timescale 1ns/10ps
module ivsc_core_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // enable wanted by software
  input  wire logic        gie_want,
  // vector answer
  input  wire logic        irq_pending,
  input  wire logic [15:0] irq_vector_addr,
  // core side
  output logic             global_irq_enable,
  output logic [15:0]      fetch_addr
);
  // enable is a registered status bit, so it lags software by a cycle
  always @(posedge clk_sys) begin
    global_irq_enable <= rst_n & gie_want;
    if (irq_pending) fetch_addr <= irq_vector_addr;
  end
endmodule // ivsc_core_model

// ---- verif/ivsc_top_tb.sv ----
// self-checking bench for the vector and sfr controller
`timescale 1ns/10ps
module ivsc_top_tb;
  import ivsc_pkg::*;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
  logic clk_sys = 0, rst_n = 0, clk_en = 1, poc = 0, gie_want = 0, pin = 0, nmi_mode = 0;
  logic pin_rst = 0, osc = 0, fl = 0, key = 0, wov = 0, wint = 0, tick = 0, gie, pend;
  logic [7:0] rdata, p1 = 0, p2 = 0;
  logic [2:0] cc = 0;
  logic [15:0] preq = 0, vaddr, fetch, v;
  logic [3:0] lvl, hl;
  ivsc_sfr_req_t req = '0;
  int bad_count = 0, compares = 0, seed = 71, cyc = 0, r;
  logic [7:0] expq[$];
  logic rd_q = 0;
  logic [7:0] rd_exp;
  logic [7:0] fullv [6] = '{8'h33, 8'h80, 8'h12, 8'h80, 8'hff, 8'hff};
  ivsc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .power_on_clear(poc),
    .sfr_req(req), .sfr_rdata(rdata), .global_irq_enable(gie), .reset_nmi_pin(pin),
    .pin_nmi_mode(nmi_mode), .pin_reset_event(pin_rst), .osc_fault_detect(osc),
    .flash_violation_event(fl), .flash_key_violation(key), .watchdog_overflow(wov),
    .watchdog_interval_mode(wint), .tick_timer_event(tick), .periph_req(preq),
    .compare_channel_flag(cc), .port_one_pin_flags(p1), .port_two_pin_flags(p2),
    .irq_pending(pend), .irq_vector_addr(vaddr), .irq_level(lvl));
  ivsc_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .gie_want(gie_want),
    .irq_pending(pend), .irq_vector_addr(vaddr), .global_irq_enable(gie), .fetch_addr(fetch));
  always #4 clk_sys = ~clk_sys;
  // read data lags the strobe by one cycle; oldest note is the expectation
  always @(posedge clk_sys) begin
    cyc++;
    // pop once so a mismatch message cannot eat the next note
    if (rd_q) begin
      rd_exp = expq.pop_front();
      `CHK(rdata, rd_exp)
    end
    rd_q <= req.rd;
    if (cyc > 4000) begin bad_count++; report_and_stop(); end
  end
  task automatic step(int n); repeat (n) @(posedge clk_sys); #1; endtask
  // one byte access, then an idle cycle so the strobe is never re-driven at once
  task automatic sfr(logic w, logic [3:0] a, logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w) expq.push_back(d);
    step(1);
    req = '0;
    step(1);
  endtask
  task automatic pulse(ref logic s); s = 1; step(1); s = 0; endtask
  task automatic expect_irq(logic p, logic [3:0] l);
    step(6);
    `CHK(pend, p)
    if (p) begin `CHK(lvl, l) `CHK(fetch, VECTOR_BASE | {l, 1'b0}) end
  endtask
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    step(12);
    rst_n = 1;
    step(2);
    for (int a = 0; a < 16; a++) sfr(0, a[3:0], 8'h00);
    for (int a = 0; a < 6; a++) sfr(1, a[3:0], 8'hff);
    for (int a = 0; a < 6; a++) sfr(0, a[3:0], fullv[a]);
    pulse(poc);
    for (int a = 0; a < 6; a++) sfr(0, a[3:0], a == 2 ? 8'h12 : 8'h00);
    sfr(1, IFG_FIRST_OFFSET, 8'h00);
    $display("sfr test done");
    // random groups and module lines against a priority model
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      {gie_want, cc, p1, p2} = r[19:0];
      preq = 16'($random(seed)) & 16'h3bcc;
      v = gie_want ? (preq | {10'h0, |cc, |p1, 2'b00, |p2, 1'b0}) : 16'h0;
      for (int b = 0; b < 16; b++) if (v[b]) hl = 4'(b);
      expect_irq(|v, hl);
    end
    {gie_want, cc, p1, p2, preq} = '0;
    $display("priority test done");
    sfr(1, IE_FIRST_OFFSET, 8'h02);
    pulse(osc);
    expect_irq(1, PRIO_NMI);
    sfr(0, IFG_FIRST_OFFSET, 8'h02);
    sfr(1, IFG_FIRST_OFFSET, 8'h00);
    sfr(1, IE_FIRST_OFFSET, 8'h10);
    pulse(osc);
    expect_irq(0, 0);
    nmi_mode = 1;
    pin = 1;
    sfr(1, IFG_FIRST_OFFSET, 8'h00);
    expect_irq(1, PRIO_NMI);
    sfr(0, IFG_FIRST_OFFSET, 8'h10);
    sfr(1, IE_FIRST_OFFSET, 8'h20);
    {pin, nmi_mode, fl} = 3'b001;
    expect_irq(1, PRIO_NMI);
    fl = 0;
    $display("nmi test done");
    sfr(1, IE_FIRST_OFFSET, 8'h01);
    gie_want = 1;
    sfr(1, IFG_FIRST_OFFSET, 8'h00);
    pulse(wov);
    expect_irq(0, 0);
    wint = 1;
    expect_irq(1, PRIO_WDOG);
    sfr(1, IFG_FIRST_OFFSET, 8'h00);
    sfr(0, IFG_FIRST_OFFSET, 8'h01);
    nmi_mode = 1;
    pulse(pin_rst);
    sfr(0, IFG_FIRST_OFFSET, 8'h01);
    nmi_mode = 0;
    pulse(pin_rst);
    sfr(0, IFG_FIRST_OFFSET, 8'h00);
    pulse(key);
    sfr(0, IFG_FIRST_OFFSET, 8'h01);
    wint = 0;
    sfr(1, IE_SECOND_OFFSET, 8'h80);
    pulse(tick);
    expect_irq(1, PRIO_TICK);
    $display("watchdog and tick test done");
    // frozen state must hold the old vector until the enable returns
    clk_en = 0;
    p1 = 8'h01;
    expect_irq(1, PRIO_TICK);
    clk_en = 1;
    expect_irq(1, PRIO_PORT_ONE);
    p1 = 8'h00;
    // mid-run power-up reset is the other way to drop the watchdog flag
    rst_n = 0;
    step(2);
    rst_n = 1;
    step(2);
    sfr(0, IFG_FIRST_OFFSET, 8'h00);
    $display("enable and reset test done");
    report_and_stop();
  end
endmodule // ivsc_top_tb
